// ==== dps_map.vh ====
`ifndef DPS_MAP_VH
`define DPS_MAP_VH

// ==========================================================
// Serial word
`define DPS_WORD_W 23
`define DPS_POS_DEST1 0
`define DPS_POS_DEST2 1
`define DPS_POS_TEST1 2
`define DPS_POS_TEST2 3
`define DPS_POS_REF_LSB 4
`define DPS_POS_REF_MSB 17
`define DPS_POS_CUR 18
`define DPS_POS_MON 2
`define DPS_POS_MOD 3
`define DPS_POS_POL 4
`define DPS_POS_SWL_LSB 5
`define DPS_POS_SWL_MSB 11
`define DPS_POS_MAIN_LSB 12
`define DPS_POS_MAIN_MSB 22

// ==========================================================
// Destination codes, {second, first}
`define DPS_DEST_IF_REF 2'h0
`define DPS_DEST_RF_REF 2'h1
`define DPS_DEST_IF_CNT 2'h2
`define DPS_DEST_RF_CNT 2'h3

// ==========================================================
// Reset values of the latches
`define DPS_RST_REF 14'h0003
`define DPS_RST_MAIN 11'h003
`define DPS_RST_SWL 7'h00

// ==========================================================
// Prescaler modulus bases
`define DPS_IF_BASE_HI 8'h08
`define DPS_IF_BASE_LO 8'h10
`define DPS_RF_BASE_HI 8'h40
`define DPS_RF_BASE_LO 8'h80

// ==========================================================
// Lock detect and restart limiting
`define DPS_LOCK_OSC 3'h2
`define DPS_UNLOCK_OSC 3'h4
`define DPS_LOCK_CYCLES 2'h3
`define DPS_RESTART_CYCLES 3'h4
`define DPS_RESTART_WIDTH 4'h8

`endif

// ==== dps_swallow_div.v ====
`timescale 1ns/1ns
`include "dps_map.vh"

module dps_swallow_div (
    input wire clk_in,
    input wire srst_in,
    input wire run_in,
    input wire vco_edge_in,
    input wire [7:0] base_in,
    input wire [10:0] main_in,
    input wire [6:0] swallow_in,
    output reg pulse_out
);

    reg [7:0] pre_cnt;
    reg [10:0] main_cnt;
    reg [6:0] swl_cnt;
    wire [7:0] pre_last;

    assign pre_last = (swl_cnt != 7'h00) ? base_in : base_in - 8'h01;

    // ==========================================================
    // Prescaler, swallow and main counters
    always @(posedge clk_in) begin
        if (srst_in || !run_in) begin
            pre_cnt <= 8'h00;
            main_cnt <= main_in;
            swl_cnt <= swallow_in;
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= 1'b0;
            if (vco_edge_in) begin
                if (pre_cnt == pre_last) begin
                    pre_cnt <= 8'h00;
                    if (swl_cnt != 7'h00) begin
                        swl_cnt <= swl_cnt - 7'h01;
                    end
                    if (main_cnt <= 11'h001) begin
                        main_cnt <= main_in;
                        swl_cnt <= swallow_in;
                        pulse_out <= 1'b1;
                    end else begin
                        main_cnt <= main_cnt - 11'h001;
                    end
                end else begin
                    pre_cnt <= pre_cnt + 8'h01;
                end
            end
        end
    end

endmodule // dps_swallow_div

// ==== dps_phase_det.v ====
`timescale 1ns/1ns
`include "dps_map.vh"

module dps_phase_det (
    input wire clk_in,
    input wire srst_in,
    input wire run_in,
    input wire ref_pulse_in,
    input wire vco_pulse_in,
    input wire osc_edge_in,
    input wire polarity_in,
    output reg pump_out,
    output reg pump_oe_out,
    output reg locked_out
);

    reg up;
    reg dn;
    reg run_q;
    reg [2:0] err_osc;
    reg [3:0] err_clk;
    reg [2:0] restart_left;
    reg [1:0] good_cnt;
    reg cycle_bad;
    wire next_up;
    wire next_dn;
    wire limited;

    assign next_up = (up | ref_pulse_in) & ~(dn | vco_pulse_in);
    assign next_dn = (dn | vco_pulse_in) & ~(up | ref_pulse_in);
    assign limited = (restart_left != 3'h0) && (err_clk >= `DPS_RESTART_WIDTH);

    always @(posedge clk_in) begin
        if (srst_in || !run_in) begin
            up <= 1'b0;
            dn <= 1'b0;
            run_q <= 1'b0;
            err_osc <= 3'h0;
            err_clk <= 4'h0;
            restart_left <= 3'h0;
            good_cnt <= 2'h0;
            cycle_bad <= 1'b0;
            locked_out <= 1'b0;
            pump_out <= 1'b0;
            pump_oe_out <= 1'b0;
        end else begin
            up <= next_up;
            dn <= next_dn;
            run_q <= 1'b1;
            if (!run_q) begin
                restart_left <= `DPS_RESTART_CYCLES;
            end else if (ref_pulse_in && restart_left != 3'h0) begin
                restart_left <= restart_left - 3'h1;
            end
            if (up | dn) begin
                if (osc_edge_in && err_osc != 3'h7) begin
                    err_osc <= err_osc + 3'h1;
                end
                if (err_clk != 4'hf) begin
                    err_clk <= err_clk + 4'h1;
                end
            end else begin
                err_osc <= 3'h0;
                err_clk <= 4'h0;
            end
            if (err_osc > `DPS_LOCK_OSC) begin
                cycle_bad <= 1'b1;
            end
            if (err_osc >= `DPS_UNLOCK_OSC) begin
                locked_out <= 1'b0;
                good_cnt <= 2'h0;
            end else if (ref_pulse_in) begin
                // A wide error in the closing cycle must not be lost, so the reload repeats the set test
                cycle_bad <= (err_osc > `DPS_LOCK_OSC);
                if (cycle_bad) begin
                    good_cnt <= 2'h0;
                end else if (good_cnt != `DPS_LOCK_CYCLES) begin
                    good_cnt <= good_cnt + 2'h1;
                end else begin
                    locked_out <= 1'b1;
                end
            end
            pump_out <= ~(up ^ polarity_in);
            pump_oe_out <= (up | dn) & ~limited;
        end
    end

endmodule // dps_phase_det

// ==== dps_top.v ====
// Overview of operation
// - Shift data in on serial clock rise
// - Strobe rise copies word to one latch
// - Two select bits choose destination latch
// - Reference word: select, test, ratio, current
// - Counter word: select, monitor, modulus, polarity, counts
// - Reference ratio fourteen bits, three minimum
// - Main ratio eleven bits, three minimum
// - Swallow seven bits, below main count
// - Modulus select picks small or large prescaler
// - Pulse swallow divide compared with reference
// - Test pair routes phase clock to monitor
// - Monitor select picks phase clock or lock
// - Polarity select swaps pump drive sense
// - Current select picks large pump drive
// - Low power save input sleeps loop
// - Sleeping loop pump is high impedance
// - Limit error pulses after waking
// - Lock after four narrow error cycles
// - Lock widths from oscillator periods
// - Independent power save per loop
`timescale 1ns/1ns
`include "dps_map.vh"

module dps_top (
    input wire CLK_IN,
    input wire SRST_IN,
    input wire SER_CLK_IN,
    input wire SER_DATA_IN,
    input wire LOAD_STROBE_IN,
    input wire POWER_SAVE_IF_N_IN,
    input wire POWER_SAVE_RF_N_IN,
    input wire REF_OSC_IN,
    input wire VCO_IF_IN,
    input wire VCO_RF_IN,
    output wire PUMP_IF_OUT,
    output wire PUMP_IF_OE_OUT,
    output reg PUMP_IF_HI_CUR_OUT,
    output wire PUMP_RF_OUT,
    output wire PUMP_RF_OE_OUT,
    output reg PUMP_RF_HI_CUR_OUT,
    output reg MONITOR_OUT
);

    // ==========================================================
    // Pin synchronisers
    // Bit order: 0 serial clock, 1 data, 2 strobe, 3 IF save,
    // 4 RF save, 5 oscillator, 6 IF VCO, 7 RF VCO
    reg [7:0] sync1;
    reg [7:0] sync2;
    reg [7:0] sync3;
    wire [7:0] rise;

    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
            sync3 <= 8'h00;
        end else begin
            sync1 <= {VCO_RF_IN, VCO_IF_IN, REF_OSC_IN, POWER_SAVE_RF_N_IN,
                      POWER_SAVE_IF_N_IN, LOAD_STROBE_IN, SER_DATA_IN, SER_CLK_IN};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Edges are taken from the second and third stages only
    assign rise = sync2 & ~sync3;

    // ==========================================================
    // Loop run levels
    wire run_if;
    wire run_rf;

    assign run_if = sync2[3];
    assign run_rf = sync2[4];

    // ==========================================================
    // Shift register
    reg [`DPS_WORD_W-1:0] shift_word;

    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            shift_word <= {`DPS_WORD_W{1'b0}};
        end else if (rise[0]) begin
            // first bit ends at the top
            shift_word <= {shift_word[`DPS_WORD_W-2:0], sync2[1]};
        end
    end

    // ==========================================================
    // Latches
    reg [13:0] ref_if;
    reg [13:0] ref_rf;
    reg [10:0] main_if;
    reg [10:0] main_rf;
    reg [6:0] swl_if;
    reg [6:0] swl_rf;
    reg mod_sel_if;
    reg mod_sel_rf;
    reg pol_if;
    reg pol_rf;
    reg [1:0] test_sel;
    reg mon_sel;
    wire [1:0] dest;

    // select bits, first in bit zero
    assign dest = {shift_word[`DPS_POS_DEST2], shift_word[`DPS_POS_DEST1]};

    // Test pair sits at the same place in both reference words
    function [1:0] test_pair;
        input [`DPS_WORD_W-1:0] w;
        begin
            test_pair = {w[`DPS_POS_TEST2], w[`DPS_POS_TEST1]};
        end
    endfunction

    // Test pair and monitor select are shared, so the last word carrying them wins
    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            ref_if <= `DPS_RST_REF;
            ref_rf <= `DPS_RST_REF;
            main_if <= `DPS_RST_MAIN;
            main_rf <= `DPS_RST_MAIN;
            swl_if <= `DPS_RST_SWL;
            swl_rf <= `DPS_RST_SWL;
            mod_sel_if <= 1'b0;
            mod_sel_rf <= 1'b0;
            pol_if <= 1'b0;
            pol_rf <= 1'b0;
            test_sel <= 2'h0;
            mon_sel <= 1'b0;
            PUMP_IF_HI_CUR_OUT <= 1'b0;
            PUMP_RF_HI_CUR_OUT <= 1'b0;
        end else if (rise[2]) begin
            case (dest)
                `DPS_DEST_IF_REF: begin
                    ref_if <= shift_word[`DPS_POS_REF_MSB:`DPS_POS_REF_LSB];
                    test_sel <= test_pair(shift_word);
                    PUMP_IF_HI_CUR_OUT <= shift_word[`DPS_POS_CUR];
                end
                `DPS_DEST_RF_REF: begin
                    ref_rf <= shift_word[`DPS_POS_REF_MSB:`DPS_POS_REF_LSB];
                    test_sel <= test_pair(shift_word);
                    PUMP_RF_HI_CUR_OUT <= shift_word[`DPS_POS_CUR];
                end
                `DPS_DEST_IF_CNT: begin
                    main_if <= shift_word[`DPS_POS_MAIN_MSB:`DPS_POS_MAIN_LSB];
                    swl_if <= shift_word[`DPS_POS_SWL_MSB:`DPS_POS_SWL_LSB];
                    mod_sel_if <= shift_word[`DPS_POS_MOD];
                    pol_if <= shift_word[`DPS_POS_POL];
                    mon_sel <= shift_word[`DPS_POS_MON];
                end
                default: begin
                    main_rf <= shift_word[`DPS_POS_MAIN_MSB:`DPS_POS_MAIN_LSB];
                    swl_rf <= shift_word[`DPS_POS_SWL_MSB:`DPS_POS_SWL_LSB];
                    mod_sel_rf <= shift_word[`DPS_POS_MOD];
                    pol_rf <= shift_word[`DPS_POS_POL];
                    mon_sel <= shift_word[`DPS_POS_MON];
                end
            endcase
        end
    end

    // ==========================================================
    // Reference dividers
    reg [13:0] ref_cnt_if;
    reg [13:0] ref_cnt_rf;
    reg ref_pulse_if;
    reg ref_pulse_rf;

    // Wrap test shared by both reference counters
    function ref_end;
        input [13:0] cnt;
        input [13:0] ratio;
        begin
            ref_end = (cnt >= ratio - 14'h0001);
        end
    endfunction

    // Ratios below three are not guarded; a ratio of zero then divides the oscillator by 16384
    // divide oscillator by ratio
    always @(posedge CLK_IN) begin
        if (SRST_IN || !run_if) begin
            ref_cnt_if <= 14'h0000;
            ref_pulse_if <= 1'b0;
        end else begin
            ref_pulse_if <= 1'b0;
            if (rise[5]) begin
                if (ref_end(ref_cnt_if, ref_if)) begin
                    ref_cnt_if <= 14'h0000;
                    ref_pulse_if <= 1'b1;
                end else begin
                    ref_cnt_if <= ref_cnt_if + 14'h0001;
                end
            end
        end
    end

    always @(posedge CLK_IN) begin
        if (SRST_IN || !run_rf) begin
            ref_cnt_rf <= 14'h0000;
            ref_pulse_rf <= 1'b0;
        end else begin
            ref_pulse_rf <= 1'b0;
            if (rise[5]) begin
                if (ref_end(ref_cnt_rf, ref_rf)) begin
                    ref_cnt_rf <= 14'h0000;
                    ref_pulse_rf <= 1'b1;
                end else begin
                    ref_cnt_rf <= ref_cnt_rf + 14'h0001;
                end
            end
        end
    end

    // ==========================================================
    // VCO dividers
    wire [7:0] base_if;
    wire [7:0] base_rf;
    wire vco_pulse_if;
    wire vco_pulse_rf;

    assign base_if = mod_sel_if ? `DPS_IF_BASE_HI : `DPS_IF_BASE_LO;
    assign base_rf = mod_sel_rf ? `DPS_RF_BASE_HI : `DPS_RF_BASE_LO;

    dps_swallow_div u_div_if (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .run_in(run_if),
        .vco_edge_in(rise[6]),
        .base_in(base_if),
        .main_in(main_if),
        .swallow_in(swl_if),
        .pulse_out(vco_pulse_if)
    );

    dps_swallow_div u_div_rf (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .run_in(run_rf),
        .vco_edge_in(rise[7]),
        .base_in(base_rf),
        .main_in(main_rf),
        .swallow_in(swl_rf),
        .pulse_out(vco_pulse_rf)
    );

    // ==========================================================
    // Phase detectors and lock detect
    wire lock_if;
    wire lock_rf;

    dps_phase_det u_pd_if (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .run_in(run_if),
        .ref_pulse_in(ref_pulse_if),
        .vco_pulse_in(vco_pulse_if),
        .osc_edge_in(rise[5]),
        .polarity_in(pol_if),
        .pump_out(PUMP_IF_OUT),
        .pump_oe_out(PUMP_IF_OE_OUT),
        .locked_out(lock_if)
    );

    dps_phase_det u_pd_rf (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .run_in(run_rf),
        .ref_pulse_in(ref_pulse_rf),
        .vco_pulse_in(vco_pulse_rf),
        .osc_edge_in(rise[5]),
        .polarity_in(pol_rf),
        .pump_out(PUMP_RF_OUT),
        .pump_oe_out(PUMP_RF_OE_OUT),
        .locked_out(lock_rf)
    );

    // ==========================================================
    // Monitor output
    // Phase clocks are shown as toggles so each comparison is visible as an edge
    reg tog_ref_if;
    reg tog_ref_rf;
    reg tog_vco_if;
    reg tog_vco_rf;
    reg next_monitor;
    wire lock_all;

    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            tog_ref_if <= 1'b0;
            tog_ref_rf <= 1'b0;
            tog_vco_if <= 1'b0;
            tog_vco_rf <= 1'b0;
        end else begin
            tog_ref_if <= tog_ref_if ^ ref_pulse_if;
            tog_ref_rf <= tog_ref_rf ^ ref_pulse_rf;
            tog_vco_if <= tog_vco_if ^ vco_pulse_if;
            tog_vco_rf <= tog_vco_rf ^ vco_pulse_rf;
        end
    end

    assign lock_all = (lock_if | ~run_if) & (lock_rf | ~run_rf);

    always @* begin
        if (mon_sel) begin
            case (test_sel)
                2'h0: next_monitor = tog_ref_if;
                2'h1: next_monitor = tog_ref_rf;
                2'h2: next_monitor = tog_vco_if;
                2'h3: next_monitor = tog_vco_rf;
                default: next_monitor = 1'b0;
            endcase
        end else begin
            next_monitor = lock_all;
        end
    end

    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            MONITOR_OUT <= 1'b0;
        end else begin
            MONITOR_OUT <= next_monitor;
        end
    end

endmodule // dps_top

// ==== dps_host.sv ====
`timescale 1ns/1ns

module dps_host (
    input wire clk_in,
    output reg ser_clk_out,
    output reg ser_data_out,
    output reg load_strobe_out
);
// ==========
// Serial link starts low; clock and strobe idle low between words
initial begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    load_strobe_out = 1'b0;
end

// ==========
// Word transfer
task send_word(input [22:0] w);
    integer k;
    begin
        for (k = 22; k >= 0; k = k - 1) begin
            @(posedge clk_in);
            ser_data_out <= w[k];
            repeat (2) @(posedge clk_in);
            ser_clk_out <= 1'b1;
            repeat (3) @(posedge clk_in);
            ser_clk_out <= 1'b0;
        end
        // Released data shows the inverse so a stale bit cannot pass
        @(posedge clk_in);
        ser_data_out <= ~w[0];
        repeat (3) @(posedge clk_in);
        load_strobe_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        load_strobe_out <= 1'b0;
        repeat (3) @(posedge clk_in);
    end
endtask
endmodule // dps_host

// ==== dps_top_chk.sv ====
`timescale 1ns/1ns

module dps_top_chk (
    input wire CLK_IN,
    input wire SRST_IN,
    input wire LOAD_STROBE_IN,
    input wire POWER_SAVE_IF_N_IN,
    input wire POWER_SAVE_RF_N_IN,
    input wire PUMP_IF_OE_OUT,
    input wire PUMP_RF_OE_OUT,
    input wire PUMP_IF_HI_CUR_OUT,
    input wire PUMP_RF_HI_CUR_OUT,
    input wire MONITOR_OUT
);
// ==========
// Wake age and drive run length
reg [9:0] wake_cnt;
reg [5:0] oe_run;
always @(posedge CLK_IN) begin
    if (SRST_IN || !POWER_SAVE_IF_N_IN)
        wake_cnt <= 10'h000;
    else if (wake_cnt != 10'h3ff)
        wake_cnt <= wake_cnt + 10'h001;
end
always @(posedge CLK_IN) begin
    if (SRST_IN || !POWER_SAVE_IF_N_IN || !PUMP_IF_OE_OUT)
        oe_run <= 6'h00;
    else if (oe_run != 6'h3f)
        oe_run <= oe_run + 6'h01;
end

// ==========
// Assertions
default clocking cb @(posedge CLK_IN);
endclocking
default disable iff (SRST_IN);

restart_limit_a: assert property (wake_cnt < 10'h1c0 |-> oe_run <= 6'h08)
    else $error("pump drive too long after wake");
sleep_if_hiz_a: assert property (!POWER_SAVE_IF_N_IN [*5] |-> !PUMP_IF_OE_OUT)
    else $error("sleeping first loop drives pump");
sleep_rf_hiz_a: assert property (!POWER_SAVE_RF_N_IN [*5] |-> !PUMP_RF_OE_OUT)
    else $error("sleeping second loop drives pump");
wake_if_quiet_a: assert property ($rose(POWER_SAVE_IF_N_IN) |-> !PUMP_IF_OE_OUT [*2])
    else $error("first loop pump drives at wake");
wake_rf_quiet_a: assert property ($rose(POWER_SAVE_RF_N_IN) |-> !PUMP_RF_OE_OUT [*2])
    else $error("second loop pump drives at wake");
if_cur_load_a: assert property ($changed(PUMP_IF_HI_CUR_OUT) |->
    ($past(LOAD_STROBE_IN, 2) || $past(LOAD_STROBE_IN, 3) || $past(LOAD_STROBE_IN, 4)))
    else $error("first current select changed without load");
rf_cur_load_a: assert property ($changed(PUMP_RF_HI_CUR_OUT) |->
    ($past(LOAD_STROBE_IN, 2) || $past(LOAD_STROBE_IN, 3) || $past(LOAD_STROBE_IN, 4)))
    else $error("second current select changed without load");
reset_clear_a: assert property ($fell(SRST_IN) |-> !PUMP_IF_HI_CUR_OUT && !PUMP_RF_HI_CUR_OUT
    && !PUMP_IF_OE_OUT && !PUMP_RF_OE_OUT)
    else $error("outputs not cleared by reset");

cover property ($rose(PUMP_IF_OE_OUT));
cover property ($rose(MONITOR_OUT));
cover property ($changed(PUMP_RF_HI_CUR_OUT));
endmodule // dps_top_chk

bind dps_top dps_top_chk u_dps_top_chk (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .LOAD_STROBE_IN(LOAD_STROBE_IN),
    .POWER_SAVE_IF_N_IN(POWER_SAVE_IF_N_IN), .POWER_SAVE_RF_N_IN(POWER_SAVE_RF_N_IN),
    .PUMP_IF_OE_OUT(PUMP_IF_OE_OUT), .PUMP_RF_OE_OUT(PUMP_RF_OE_OUT), .PUMP_IF_HI_CUR_OUT(PUMP_IF_HI_CUR_OUT),
    .PUMP_RF_HI_CUR_OUT(PUMP_RF_HI_CUR_OUT), .MONITOR_OUT(MONITOR_OUT));

// ==== dps_top_tb.sv ====
`timescale 1ns/1ns

module dps_top_tb;
reg clk, srst, ps_if_n, ps_rf_n, osc, vco_if, vco_rf, vco_on, found;
wire ser_clk, ser_data, strobe, pump_if, pump_if_oe, cur_if, pump_rf, pump_rf_oe, cur_rf, mon;
integer errors, tests_run, osc_cnt, n, t;

always #20 clk = ~clk;

// ==========
// Oscillator; the vco pins copy it so matched ratios line up
always @(posedge clk) begin
    osc_cnt <= (osc_cnt == 2) ? 0 : osc_cnt + 1;
    if (osc_cnt == 2) begin
        osc <= ~osc;
        vco_if <= vco_on & ~osc;
        vco_rf <= vco_on & ~osc;
    end
end

dps_host u_dps_host (.clk_in(clk), .ser_clk_out(ser_clk), .ser_data_out(ser_data), .load_strobe_out(strobe));
dps_top u_dps_top (.CLK_IN(clk), .SRST_IN(srst), .SER_CLK_IN(ser_clk), .SER_DATA_IN(ser_data),
    .LOAD_STROBE_IN(strobe), .POWER_SAVE_IF_N_IN(ps_if_n), .POWER_SAVE_RF_N_IN(ps_rf_n), .REF_OSC_IN(osc),
    .VCO_IF_IN(vco_if), .VCO_RF_IN(vco_rf), .PUMP_IF_OUT(pump_if), .PUMP_IF_OE_OUT(pump_if_oe),
    .PUMP_IF_HI_CUR_OUT(cur_if), .PUMP_RF_OUT(pump_rf), .PUMP_RF_OE_OUT(pump_rf_oe),
    .PUMP_RF_HI_CUR_OUT(cur_rf), .MONITOR_OUT(mon));

// ==========
// Helpers
function [22:0] ref_w(input [1:0] d, input [1:0] tp, input [13:0] r, input cs);
    ref_w = {4'hf, cs, r, tp, d};
endfunction
function [22:0] cnt_w(input [1:0] d, input ms, input md, input pol, input [6:0] a, input [10:0] nn);
    cnt_w = {nn, a, pol, md, ms, d};
endfunction
task check(input [31:0] got, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
endtask
task test_done;
    begin
        $display("compares %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    end
endtask
task cyc(input integer k);
    begin
        repeat (k) @(posedge clk);
        #1;
    end
endtask
task drive(input a, input b, input v);
    begin
        @(posedge clk);
        ps_if_n <= a;
        ps_rf_n <= b;
        vco_on <= v;
    end
endtask
task watch(input sel, input v, input integer bound, output f);
    integer i;
    begin
        f = 1'b0;
        for (i = 0; i < bound && !f; i = i + 1) begin
            cyc(1);
            f = ((sel ? pump_if_oe : mon) === v);
        end
    end
endtask
task load_cur(input [22:0] w, input [1:0] exp);
    begin
        u_dps_host.send_word(w);
        cyc(4);
        check({cur_rf, cur_if}, exp);
    end
endtask
task run_lock(input rf, input [13:0] r, input md, input [6:0] a, input [10:0] nn, input exp);
    begin
        drive(1'b0, 1'b0, 1'b1);
        u_dps_host.send_word(ref_w({1'b0, rf}, 2'h0, r, 1'b0));
        u_dps_host.send_word(cnt_w({1'b1, rf}, 1'b0, md, 1'b1, a, nn));
        drive(!rf, rf, 1'b1);
        cyc(8);
        check(mon, 1'b0);
        watch(1'b0, 1'b1, 72 * r, found);
        check(found, exp);
    end
endtask

// ==========
// Main sequence
initial begin
    clk = 1'b0;
    srst = 1'b1;
    ps_if_n = 1'b0;
    ps_rf_n = 1'b0;
    osc = 1'b0;
    vco_if = 1'b0;
    vco_rf = 1'b0;
    vco_on = 1'b0;
    osc_cnt = 0;
    errors = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    cyc(30);
    check({cur_rf, cur_if, pump_rf_oe, pump_if_oe, mon}, 5'h01);
    $display("test reset done");
    load_cur(ref_w(2'h0, 2'h0, 14'h0018, 1'b1), 2'h1);
    load_cur(ref_w(2'h1, 2'h0, 14'h0018, 1'b1), 2'h3);
    load_cur(cnt_w(2'h2, 1'b0, 1'b1, 1'b1, 7'h00, 11'h003), 2'h3);
    load_cur(ref_w(2'h0, 2'h0, 14'h0018, 1'b0), 2'h2);
    load_cur(ref_w(2'h1, 2'h0, 14'h0018, 1'b0), 2'h0);
    $display("test latches done");
    // ratios in range, swallow below main
    run_lock(1'b0, 14'h0018, 1'b1, 7'h00, 11'h003, 1'b1);
    run_lock(1'b0, 14'h0043, 1'b0, 7'h03, 11'h004, 1'b1);
    run_lock(1'b0, 14'h0018, 1'b1, 7'h01, 11'h004, 1'b0);
    run_lock(1'b1, 14'h0103, 1'b1, 7'h03, 11'h004, 1'b1);
    run_lock(1'b1, 14'h0180, 1'b0, 7'h00, 11'h003, 1'b1);
    $display("test divide done");
    drive(1'b0, 1'b0, 1'b1);
    u_dps_host.send_word(cnt_w(2'h2, 1'b1, 1'b1, 1'b1, 7'h00, 11'h003));
    drive(1'b1, 1'b0, 1'b1);
    cyc(300);
    for (t = 0; t < 4; t = t + 1) begin
        u_dps_host.send_word(ref_w(2'h0, t[1:0], 14'h0018, 1'b0));
        n = 0;
        repeat (576) begin
            found = mon;
            cyc(1);
            n = n + (mon !== found);
        end
        check((t[0] == 1'b0) ? (n >= 3 && n <= 5) : (n == 0), 1'b1);
    end
    u_dps_host.send_word(cnt_w(2'h2, 1'b0, 1'b1, 1'b1, 7'h00, 11'h003));
    watch(1'b0, 1'b1, 2000, found);
    check(found, 1'b1);
    drive(1'b1, 1'b0, 1'b0);
    watch(1'b0, 1'b0, 300, found);
    check(found, 1'b1);
    watch(1'b1, 1'b1, 300, found);
    check({found, pump_if}, 2'h3);
    cyc(12);
    check(pump_if_oe, 1'b1);
    u_dps_host.send_word(cnt_w(2'h2, 1'b0, 1'b1, 1'b0, 7'h00, 11'h003));
    cyc(4);
    check({pump_if_oe, pump_if}, 2'h2);
    drive(1'b0, 1'b0, 1'b0);
    cyc(8);
    check(pump_if_oe, 1'b0);
    drive(1'b1, 1'b0, 1'b0);
    watch(1'b1, 1'b1, 400, found);
    n = 0;
    while (pump_if_oe === 1'b1 && n < 40) begin
        n = n + 1;
        cyc(1);
    end
    check({found, n <= 8}, 2'h3);
    u_dps_host.send_word(cnt_w(2'h3, 1'b0, 1'b0, 1'b0, 7'h00, 11'h003));
    drive(1'b0, 1'b1, 1'b0);
    n = 0;
    while (pump_rf_oe !== 1'b1 && n < 2600) begin
        n = n + 1;
        cyc(1);
    end
    check({pump_rf_oe, pump_rf, pump_if_oe}, 3'h4);
    $display("test pump done");
    test_done;
end

// ==========
// Hang guard
initial begin
    #4000000;
    errors = errors + 1;
    test_done;
end
endmodule // dps_top_tb
